//--- pkg/radio_ctrl_pkg.sv
// constants and types shared by the radio state control block
package radio_ctrl_pkg;

  // ************************************************************
  // state numbers shown in the radio state register
  // ************************************************************
  typedef enum logic [4:0] {
    ST_SLEEP    = 5'h00,
    ST_IDLE     = 5'h01,
    ST_OSC_OFF  = 5'h02,
    ST_RX       = 5'h0D,
    ST_SYNC_RDY = 5'h12,
    ST_TX       = 5'h13
  } radio_state_t;

  // ************************************************************
  // field codes
  // ************************************************************
  localparam logic [5:0] PIN_SEL_CLEAR    = 6'h09;
  localparam logic [1:0] CHK_ALWAYS       = 2'h0;
  localparam logic [1:0] CHK_RSSI         = 2'h1;
  localparam logic [1:0] CHK_NOT_RX_PKT   = 2'h2;
  localparam logic [1:0] CHK_BOTH         = 2'h3;
  localparam int         NUM_GP_PINS      = 3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ          = 10_000_000;
  localparam int OSC_START_US    = 150;
  localparam int OSC_START_CYC   = (OSC_START_US * (CLK_HZ / 1_000_000));
  localparam int RESET_TIME_US   = 20;
  localparam int RESET_CYC       = (RESET_TIME_US * (CLK_HZ / 1_000_000));
  localparam int CNT_W           = 12;

endpackage

//--- src/radio_state_ctrl.sv
// radio control state machine with reset and crystal control
`timescale 1ns/1ns
module radio_state_ctrl #(
  parameter int OSC_START_CYCLES = radio_ctrl_pkg::OSC_START_CYC,
  parameter int RESET_CYCLES     = radio_ctrl_pkg::RESET_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       chip_select_n_i,
  input  wire logic       transmit_strobe_i,
  input  wire logic       synth_on_strobe_i,
  input  wire logic       receive_strobe_i,
  input  wire logic       idle_strobe_i,
  input  wire logic       reset_strobe_i,
  input  wire logic       osc_off_strobe_i,
  input  wire logic       power_down_strobe_i,
  input  wire logic       tx_underflow_i,
  input  wire logic       carrier_sense_i,
  input  wire logic       receiving_packet_i,
  input  wire logic [1:0] channel_check_mode_i,
  input  wire logic       crystal_force_on_i,
  input  wire logic [5:0] output_pin_select_i [radio_ctrl_pkg::NUM_GP_PINS],
  output logic [radio_ctrl_pkg::NUM_GP_PINS-1:0] gp_output_pin_o,
  output logic            chip_ready_n_o,
  output logic [4:0]      radio_state_register_o,
  output logic            crystal_osc_en_o,
  output logic            regulator_en_o,
  output logic            clear_channel_o
);

  // ************************************************************
  // chip select from the pin
  // ************************************************************
  logic cs_n_s;
  logic cs_n_prev_q;
  logic cs_n_prev_d;
  logic cs_fall;
  logic cs_rise;

  sync_2ff #(.RESET_VAL(1'b1)) u_cs_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (chip_select_n_i),
    .q_o   (cs_n_s)
  );

  assign cs_fall = cs_n_prev_q & ~cs_n_s;
  assign cs_rise = ~cs_n_prev_q & cs_n_s;

  // ************************************************************
  // clear channel check
  // ************************************************************
  function automatic logic chan_clear(input logic [1:0] mode,
                                      input logic       cs,
                                      input logic       rx_pkt);
    unique case (mode)
      radio_ctrl_pkg::CHK_ALWAYS:     chan_clear = 1'b1;
      radio_ctrl_pkg::CHK_RSSI:       chan_clear = ~cs;
      radio_ctrl_pkg::CHK_NOT_RX_PKT: chan_clear = ~rx_pkt;
      radio_ctrl_pkg::CHK_BOTH:       chan_clear = ~cs & ~rx_pkt;
    endcase
  endfunction

  logic clear_now;
  assign clear_now = chan_clear(channel_check_mode_i, carrier_sense_i,
                                receiving_packet_i);

  // ************************************************************
  // state machine
  // ************************************************************
  radio_ctrl_pkg::radio_state_t state_q;
  radio_ctrl_pkg::radio_state_t state_d;
  logic                     osc_on_q;
  logic                     osc_on_d;
  logic                     reg_on_q;
  logic                     reg_on_d;
  logic                     stop_pend_q;
  logic                     stop_pend_d;
  logic [radio_ctrl_pkg::CNT_W-1:0] wait_q;
  logic [radio_ctrl_pkg::CNT_W-1:0] wait_d;
  logic                     ready_n_q;
  logic                     ready_n_d;
  logic                     clear_q;
  logic                     clear_d;
  logic [radio_ctrl_pkg::NUM_GP_PINS-1:0] pins_q;
  logic [radio_ctrl_pkg::NUM_GP_PINS-1:0] pins_d;

  // start-up wait: osc settle after power-up or wake, reset time after reset strobe
  localparam logic [radio_ctrl_pkg::CNT_W-1:0] OSC_LOAD =
    radio_ctrl_pkg::CNT_W'(OSC_START_CYCLES);
  localparam logic [radio_ctrl_pkg::CNT_W-1:0] RST_LOAD =
    radio_ctrl_pkg::CNT_W'(RESET_CYCLES);

  always_comb begin
    state_d     = state_q;
    osc_on_d    = osc_on_q;
    reg_on_d    = reg_on_q;
    stop_pend_d = stop_pend_q;
    wait_d      = (wait_q != '0) ? wait_q - 1'b1 : wait_q;
    clear_d     = clear_now;
    for (int i = 0; i < radio_ctrl_pkg::NUM_GP_PINS; i++) begin
      pins_d[i] = (output_pin_select_i[i] == radio_ctrl_pkg::PIN_SEL_CLEAR)
                  & clear_now;
    end
    if (reset_strobe_i) begin
      // defaults restored; osc kept running, only reset time elapses
      state_d     = radio_ctrl_pkg::ST_IDLE;
      osc_on_d    = 1'b1;
      reg_on_d    = 1'b1;
      stop_pend_d = 1'b0;
      wait_d      = RST_LOAD;
    end else if (!osc_on_q || !reg_on_q) begin
      // forced crystal keeps running in sleep: no settle wait then
      if (cs_fall) begin
        osc_on_d = 1'b1;
        reg_on_d = 1'b1;
        if (!osc_on_q)
          wait_d = OSC_LOAD;
        state_d  = radio_ctrl_pkg::ST_IDLE;
      end
    end else if (stop_pend_q) begin
      if (cs_rise) begin
        stop_pend_d = 1'b0;
        osc_on_d    = crystal_force_on_i;
        reg_on_d    = (state_q != radio_ctrl_pkg::ST_SLEEP);
        if (crystal_force_on_i && state_q == radio_ctrl_pkg::ST_OSC_OFF)
          state_d = radio_ctrl_pkg::ST_IDLE;
      end
    end else if (idle_strobe_i) begin
      state_d = radio_ctrl_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        radio_ctrl_pkg::ST_IDLE: begin
          if (osc_off_strobe_i) begin
            state_d     = radio_ctrl_pkg::ST_OSC_OFF;
            stop_pend_d = 1'b1;
          end else if (power_down_strobe_i) begin
            state_d     = radio_ctrl_pkg::ST_SLEEP;
            stop_pend_d = 1'b1;
          end else if (receive_strobe_i) begin
            state_d = radio_ctrl_pkg::ST_RX;
          end else if (transmit_strobe_i) begin
            state_d = radio_ctrl_pkg::ST_TX;
          end else if (synth_on_strobe_i) begin
            state_d = radio_ctrl_pkg::ST_SYNC_RDY;
          end
        end
        radio_ctrl_pkg::ST_RX: begin
          // busy channel drops the strobe, nothing is remembered
          if (transmit_strobe_i && clear_now)
            state_d = radio_ctrl_pkg::ST_TX;
          else if (synth_on_strobe_i && clear_now)
            state_d = radio_ctrl_pkg::ST_SYNC_RDY;
        end
        radio_ctrl_pkg::ST_TX: begin
          if (tx_underflow_i)
            state_d = radio_ctrl_pkg::ST_IDLE;
          else if (receive_strobe_i)
            state_d = radio_ctrl_pkg::ST_RX;
        end
        radio_ctrl_pkg::ST_SYNC_RDY: begin
          if (transmit_strobe_i)
            state_d = radio_ctrl_pkg::ST_TX;
          else if (receive_strobe_i)
            state_d = radio_ctrl_pkg::ST_RX;
        end
        default: state_d = state_q;
      endcase
    end
    // ready only with select low, osc running and no wait pending
    ready_n_d = ~(~cs_n_s & osc_on_d & (wait_d == '0));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= radio_ctrl_pkg::ST_IDLE;
      osc_on_q    <= 1'b1;
      reg_on_q    <= 1'b1;
      stop_pend_q <= 1'b0;
      wait_q      <= OSC_LOAD;
      ready_n_q   <= 1'b1;
      clear_q     <= 1'b0;
      pins_q      <= '0;
      cs_n_prev_q <= 1'b1;
    end else begin
      state_q     <= state_d;
      osc_on_q    <= osc_on_d;
      reg_on_q    <= reg_on_d;
      stop_pend_q <= stop_pend_d;
      wait_q      <= wait_d;
      ready_n_q   <= ready_n_d;
      clear_q     <= clear_d;
      pins_q      <= pins_d;
      cs_n_prev_q <= cs_n_prev_d;
    end
  end

  assign cs_n_prev_d = cs_n_s;

  assign gp_output_pin_o        = pins_q;
  assign chip_ready_n_o         = ready_n_q;
  assign radio_state_register_o = state_q;
  assign crystal_osc_en_o       = osc_on_q;
  assign regulator_en_o         = reg_on_q;
  assign clear_channel_o        = clear_q;

  // ************************************************************
  // checks
  // ************************************************************
  a_busy_stays_rx: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == radio_ctrl_pkg::ST_RX && transmit_strobe_i && !clear_now &&
    !idle_strobe_i && !reset_strobe_i && osc_on_q && !stop_pend_q
    |=> state_q == radio_ctrl_pkg::ST_RX)
    else $error("tx strobe on busy channel left receive");
  a_clear_goes_tx: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == radio_ctrl_pkg::ST_RX && transmit_strobe_i && clear_now &&
    !idle_strobe_i && !reset_strobe_i && osc_on_q && !stop_pend_q
    |=> state_q == radio_ctrl_pkg::ST_TX)
    else $error("tx strobe on clear channel did not transmit");
  a_no_self_tx: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == radio_ctrl_pkg::ST_RX && !transmit_strobe_i &&
    !synth_on_strobe_i && !idle_strobe_i && !reset_strobe_i
    |=> state_q != radio_ctrl_pkg::ST_TX &&
        state_q != radio_ctrl_pkg::ST_SYNC_RDY)
    else $error("receive left without a strobe");
  a_pin_shows_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    output_pin_select_i[0] == radio_ctrl_pkg::PIN_SEL_CLEAR
    |=> gp_output_pin_o[0] == $past(clear_now))
    else $error("pin does not follow clear channel");
  a_mode_always: assert property (@(posedge clk_i) disable iff (rst_i)
    channel_check_mode_i == radio_ctrl_pkg::CHK_ALWAYS |-> clear_now)
    else $error("always mode reported busy");
  a_force_keeps_osc: assert property (@(posedge clk_i) disable iff (rst_i)
    crystal_force_on_i && osc_on_q && !reset_strobe_i
    |=> osc_on_q)
    else $error("crystal stopped while forced on");
  a_reset_to_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    reset_strobe_i |=> state_q == radio_ctrl_pkg::ST_IDLE && osc_on_q
    && chip_ready_n_o)
    else $error("reset strobe did not reach idle");
  a_idle_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
    idle_strobe_i && osc_on_q && !stop_pend_q && !reset_strobe_i
    |=> state_q == radio_ctrl_pkg::ST_IDLE)
    else $error("idle strobe ignored");
  a_ready_needs_osc: assert property (@(posedge clk_i) disable iff (rst_i)
    !chip_ready_n_o |-> osc_on_q && wait_q == '0)
    else $error("ready shown before crystal stable");
  a_wake_to_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !osc_on_q && cs_fall && !reset_strobe_i
    |=> osc_on_q && reg_on_q && state_q == radio_ctrl_pkg::ST_IDLE)
    else $error("select low did not wake the crystal");
  a_sleep_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    !reg_on_q && cs_fall && !reset_strobe_i
    |=> reg_on_q && osc_on_q && state_q == radio_ctrl_pkg::ST_IDLE)
    else $error("select low did not leave sleep");

endmodule

//--- src/sync_2ff.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ns
module sync_2ff #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_q;
  logic meta_d;
  logic q_q;
  logic q_d;

  always_comb begin
    meta_d = d_i;
    q_d    = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RESET_VAL;
      q_q    <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      q_q    <= q_d;
    end
  end

  assign q_o = q_q;

endmodule

//--- tb/host_model.sv
// host controller model: chip select and command strobes
`timescale 1ns/1ns
module host_model (
  input  wire logic       clk_i,
  input  wire logic       chip_ready_n_i,
  output logic            chip_select_n_o,
  output logic [6:0]      strobe_o
);
  initial begin
    chip_select_n_o = 1'b1;
    strobe_o        = 7'h00;
  end
  task automatic set_select(input logic lvl);
    @(negedge clk_i);
    chip_select_n_o = lvl;
  endtask
  // port stays unused while chip ready is awaited low, for at most 60 cycles
  task automatic wait_ready(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 60 && !ok; i++) begin
      @(negedge clk_i);
      ok = (chip_ready_n_i === 1'b0);
    end
  endtask
  // one-cycle strobe; index 0 tx 1 synth 2 rx 3 idle 4 rst 5 osc_off_state 6 pwd
  task automatic pulse(input int idx);
    @(negedge clk_i);
    strobe_o[idx] = 1'b1;
    @(negedge clk_i);
    strobe_o[idx] = 1'b0;
  endtask
  // select pulse held high 40 us (400 cycles) from its low edge
  task automatic manual_reset(output bit ok);
    set_select(1'b0);
    set_select(1'b1);
    repeat (400) @(negedge clk_i);
    set_select(1'b0);
    wait_ready(ok);
    pulse(4);
  endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the radio state control block
`timescale 1ns/1ns
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic chip_select_n, ufl, cs, pkt, force_on;
  logic [1:0] mode;
  logic [6:0] stb;
  logic [5:0] pin_sel [radio_ctrl_pkg::NUM_GP_PINS];
  logic [2:0] gp;
  logic ready_n, osc_en, reg_en, clr;
  logic [4:0] st;
  int n_fail = 0, total_checks = 0;
  bit ok;
  initial forever #50 clk_i = ~clk_i;
  host_model host (.clk_i(clk_i), .chip_ready_n_i(ready_n),
    .chip_select_n_o(chip_select_n), .strobe_o(stb));
  radio_state_ctrl #(.OSC_START_CYCLES(4), .RESET_CYCLES(2)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .chip_select_n_i(chip_select_n),
    .transmit_strobe_i(stb[0]), .synth_on_strobe_i(stb[1]),
    .receive_strobe_i(stb[2]), .idle_strobe_i(stb[3]),
    .reset_strobe_i(stb[4]), .osc_off_strobe_i(stb[5]),
    .power_down_strobe_i(stb[6]), .tx_underflow_i(ufl),
    .carrier_sense_i(cs), .receiving_packet_i(pkt),
    .channel_check_mode_i(mode), .crystal_force_on_i(force_on),
    .output_pin_select_i(pin_sel), .gp_output_pin_o(gp),
    .chip_ready_n_o(ready_n), .radio_state_register_o(st),
    .crystal_osc_en_o(osc_en), .regulator_en_o(reg_en),
    .clear_channel_o(clr));
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [7:0] sel(input int w);
    case (w)
      0: return {7'h00, ready_n};
      1: return {7'h00, osc_en};
      2: return {7'h00, reg_en};
      default: return {3'h0, st};
    endcase
  endfunction
  // bounded wait; a miss ends the run
  task automatic wait_on(input int w, input logic [7:0] v);
    int i;
    for (i = 0; i < 60 && sel(w) !== v; i++) @(negedge clk_i);
    chk(sel(w), v, "wait");
    if (sel(w) !== v) summarize();
  endtask
  task automatic sel_cycle(input int s, input logic [4:0] exp_st);
    host.pulse(s);
    chk(st, exp_st, "low power entry");
    host.set_select(1'b1);
    wait_on(1, 8'h00);
    if (s == 6) wait_on(2, 8'h00);
    host.set_select(1'b0);
    wait_on(1, 8'h01);
    chk(ready_n, 1'b1, "ready before stable");
    wait_on(3, radio_ctrl_pkg::ST_IDLE);
    wait_on(2, 8'h01);
    wait_on(0, 8'h00);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_cca();
    logic c;
    logic [2:0] exp_pins;
    logic [4:0] exp_st;
    for (int m = 0; m < 4; m++)
      for (int b = 0; b < 4; b++) begin
        mode = m[1:0];
        cs = b[0];
        pkt = b[1];
        // pin 1 takes the clear code when pkt is set, pin 2 takes it when cs is clear
        pin_sel[1] = b[1] ? radio_ctrl_pkg::PIN_SEL_CLEAR : 6'h0E;
        pin_sel[2] = b[0] ? 6'h08 : radio_ctrl_pkg::PIN_SEL_CLEAR;
        host.pulse(2);
        c = (m == 0) || (m == 1 && !cs) || (m == 2 && !pkt)
          || (m == 3 && !cs && !pkt);
        exp_pins = {b[0] ? 1'b0 : c, b[1] ? c : 1'b0, c};
        chk(clr, c, "clear flag");
        chk(gp, exp_pins, "pins");
        host.pulse(b[0] ? 1 : 0);
        if (!c)
          exp_st = radio_ctrl_pkg::ST_RX;
        else if (b[0])
          exp_st = radio_ctrl_pkg::ST_SYNC_RDY;
        else
          exp_st = radio_ctrl_pkg::ST_TX;
        chk(st, exp_st, "cca");
        cs = 1'b0;
        pkt = 1'b0;
        repeat (5) @(negedge clk_i);
        if (!c) chk(st, radio_ctrl_pkg::ST_RX, "no retry");
        host.pulse(3);
        chk(st, radio_ctrl_pkg::ST_IDLE, "idle strobe");
      end
    $display("test cca done");
  endtask
  task automatic t_events();
    mode = 2'h0;
    host.pulse(2);
    host.pulse(6);
    chk(st, radio_ctrl_pkg::ST_RX, "pwd outside idle");
    host.pulse(0);
    ufl = 1'b1;
    @(negedge clk_i);
    ufl = 1'b0;
    @(negedge clk_i);
    chk(st, radio_ctrl_pkg::ST_IDLE, "underflow");
    host.pulse(0);
    host.pulse(4);
    wait_on(0, 8'h00);
    chk(st, radio_ctrl_pkg::ST_IDLE, "reset strobe");
    $display("test events done");
  endtask
  task automatic t_power();
    sel_cycle(6, radio_ctrl_pkg::ST_SLEEP);
    sel_cycle(5, radio_ctrl_pkg::ST_OSC_OFF);
    force_on = 1'b1;
    host.pulse(6);
    host.set_select(1'b1);
    repeat (10) @(negedge clk_i);
    chk(osc_en, 1'b1, "forced osc");
    chk(reg_en, 1'b0, "forced sleep regulator");
    host.set_select(1'b0);
    wait_on(3, radio_ctrl_pkg::ST_IDLE);
    wait_on(2, 8'h01);
    wait_on(0, 8'h00);
    force_on = 1'b0;
    $display("test power done");
  endtask
  initial begin
    ufl        = 1'b0;
    cs         = 1'b0;
    pkt        = 1'b0;
    force_on   = 1'b0;
    mode       = radio_ctrl_pkg::CHK_ALWAYS;
    pin_sel[0] = 6'h09;
    pin_sel[1] = 6'h00;
    pin_sel[2] = 6'h09;
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    chk(st, radio_ctrl_pkg::ST_IDLE, "reset state");
    chk({osc_en, reg_en, ready_n}, 3'h7, "reset outputs");
    host.manual_reset(ok);
    chk(ok, 1'b1, "power-up ready");
    if (!ok) summarize();
    wait_on(0, 8'h00);
    $display("test startup done");
    t_cca();
    t_events();
    t_power();
    summarize();
  end
endmodule
